//--- rtl/analog_hysteresis_trigger.sv
// Analog hysteresis trigger with Wishbone register access
`include "trigger_cfg.svh"

// Summary of operation
// - Scaled value is analog input times gain, plus zero offset.
// - Gain ranges -10.00 to 10.00, stored in hundredths.
// - Zero offset ranges -10000 to 10000.
// - On and off thresholds each range -20000 to 20000.
// - On at least off: set above on, clear at or below off.
// - On below off: high only when on <= value < off.
// - Decimal places, 0 to 3, are display only; compare ignores them.
// - Differential mode derives off as on plus signed delta.
// - Delta ranges -20000 to 20000.
// - Negative delta uses the hysteresis rule.
// - Positive delta uses the window rule.
// - Comparator mode switches on difference of two inputs.
// - Both inputs scaled with same gain and offset, then subtracted.
module analog_hysteresis_trigger
  import trigger_pkg::*;
(
  input  wire logic        CLOCK_IN,         // 40 MHz clock
  input  wire logic        RESETN_IN,        // Async reset, active low
  input  wire logic        WB_CYC_IN,        // Wishbone cycle
  input  wire logic        WB_STB_IN,        // Wishbone strobe
  input  wire logic        WB_WE_IN,         // Wishbone write enable
  input  wire logic [7:0]  WB_ADR_IN,        // Wishbone byte address
  input  wire logic [3:0]  WB_SEL_IN,        // Wishbone byte selects
  input  wire logic [31:0] WB_DAT_IN,        // Wishbone write data
  output logic [31:0]      WB_DAT_OUT,       // Wishbone read data
  output logic             WB_ACK_OUT,       // Wishbone acknowledge
  input  wire logic [15:0] FIRST_ANALOG_IN,  // First analog value
  input  wire logic [15:0] SECOND_ANALOG_IN, // Second analog value
  input  wire logic        CYCLE_EN_IN,      // Program cycle pulse
  output logic             SWITCH_OUT,       // Binary switching output
  output logic             BUSY_OUT          // Evaluation in progress
);

  // ==========================================================
  // Helper functions
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_value,
    input logic [31:0] new_value,
    input logic [3:0]  sel
  );
    logic [31:0] result;
    result = old_value;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        result[i*8 +: 8] = new_value[i*8 +: 8];
      end
    end
    return result;
  endfunction

  function automatic logic signed [31:0] clamp(
    input logic signed [31:0] value,
    input logic signed [31:0] low,
    input logic signed [31:0] high
  );
    logic signed [31:0] result;
    result = value;
    if (value < low) begin
      result = low;
    end else if (value > high) begin
      result = high;
    end
    return result;
  endfunction

  // ==========================================================
  // Declarations
  ctrl_t              ctrl;
  settings_t          settings;
  sample_t            sample;
  eval_state_t        state;
  eval_state_t        next_state;
  logic               bus_req;
  logic               bus_write;
  logic [31:0]        written;
  logic signed [31:0] actual_x;
  logic signed [31:0] actual_y;
  logic signed [31:0] scaled_x;
  logic signed [31:0] scaled_y;
  logic signed [31:0] compared;
  logic signed [31:0] next_compared;
  logic signed [31:0] off_effective;
  logic               next_switch;
  logic [31:0]        eval_count;
  logic [31:0]        next_dat;
  logic               bus_read;
  logic               take_sample;
  logic               scaling;
  logic               deciding;
  logic signed [15:0] raw [2];
  logic signed [31:0] scaled [2];

  assign bus_req   = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  assign bus_write = bus_req && WB_WE_IN;
  assign bus_read  = bus_req && !WB_WE_IN;
  // Busy decodes only the state register, so it never glitches on inputs
  assign BUSY_OUT  = (state != ST_IDLE);

  // ==========================================================
  // Bus acknowledge: one wait cycle, dropped after one cycle
  // The request term excludes ACK, so a strobe still held is not taken twice
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      WB_ACK_OUT <= 1'b0;
    end else begin
      WB_ACK_OUT <= bus_req;
    end
  end

  // ==========================================================
  // Control register; decimals are stored for display only
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ctrl <= ctrl_t'(5'(`RESET_CTRL));
    end else if (bus_write && WB_ADR_IN == `ADDR_CTRL) begin
      if (WB_SEL_IN[0]) begin
        ctrl.mode     <= mode_t'(WB_DAT_IN[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
        ctrl.enable   <= WB_DAT_IN[`CTRL_ENABLE_BIT];
        ctrl.decimals <= WB_DAT_IN[`CTRL_DEC_MSB:`CTRL_DEC_LSB];
      end
    end
  end

  // ==========================================================
  // Parameter registers; out-of-range writes saturate at the limits
  // Bytes merge before the clamp, so a partial write saturates as a word
  always_comb begin
    case (WB_ADR_IN)
      `ADDR_GAIN:   written = merge_bytes(settings.gain, WB_DAT_IN,
                                          WB_SEL_IN);
      `ADDR_OFFSET: written = merge_bytes(settings.offset, WB_DAT_IN,
                                          WB_SEL_IN);
      `ADDR_ON:     written = merge_bytes(settings.on_level, WB_DAT_IN,
                                          WB_SEL_IN);
      `ADDR_OFF:    written = merge_bytes(settings.off_level, WB_DAT_IN,
                                          WB_SEL_IN);
      `ADDR_DELTA:  written = merge_bytes(settings.delta, WB_DAT_IN,
                                          WB_SEL_IN);
      default:      written = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      settings.gain      <= `RESET_GAIN;
      settings.offset    <= `RESET_OFFSET;
      settings.on_level  <= `RESET_ON;
      settings.off_level <= `RESET_OFF;
      settings.delta     <= `RESET_DELTA;
    end else if (bus_write) begin
      case (WB_ADR_IN)
        `ADDR_GAIN: begin
          settings.gain <= clamp(written, `GAIN_MIN, `GAIN_MAX);
        end
        `ADDR_OFFSET: begin
          settings.offset <= clamp(written, `OFFSET_MIN,
                                   `OFFSET_MAX);
        end
        `ADDR_ON: begin
          settings.on_level <= clamp(written, `LEVEL_MIN,
                                     `LEVEL_MAX);
        end
        `ADDR_OFF: begin
          settings.off_level <= clamp(written, `LEVEL_MIN,
                                      `LEVEL_MAX);
        end
        `ADDR_DELTA: begin
          settings.delta <= clamp(written, `LEVEL_MIN,
                                  `LEVEL_MAX);
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Evaluation sequencer: sample, scale, decide
  always_comb begin
    case (state)
      ST_IDLE: begin
        if (CYCLE_EN_IN && ctrl.enable) begin
          next_state = ST_SCALE;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_SCALE:  next_state = ST_DECIDE;
      ST_DECIDE: next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Sequencer decodes shared by capture, scale and decide registers
  assign take_sample = (state == ST_IDLE) && (next_state == ST_SCALE);
  assign scaling     = (state == ST_SCALE);
  assign deciding    = (state == ST_DECIDE);

  // Inputs are caught once so both channels belong to the same cycle
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sample <= '0;
    end else if (take_sample) begin
      sample.first  <= FIRST_ANALOG_IN;
      sample.second <= SECOND_ANALOG_IN;
    end
  end

  // ==========================================================
  // Scaling of both inputs with the same gain and offset
  assign raw[0]   = sample.first;
  assign raw[1]   = sample.second;
  assign scaled_x = scaled[0];
  assign scaled_y = scaled[1];

  // One scaler per channel keeps both paths identical in rounding
  for (genvar ch = 0; ch < 2; ch++) begin : g_scale
    value_scaler #(
      .IN_WIDTH (16)
    ) scale_channel (
      .value_in   (raw[ch]),
      .gain_in    (settings.gain),
      .offset_in  (settings.offset),
      .scaled_out (scaled[ch])
    );
  end

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      actual_x <= '0;
      actual_y <= '0;
    end else if (scaling) begin
      actual_x <= scaled_x;
      actual_y <= scaled_y;
    end
  end

  // ==========================================================
  // Mode selection of compared value and off threshold
  // On plus delta stays within 17 bits, so the sum cannot wrap
  always_comb begin
    next_compared = actual_x;
    off_effective = settings.off_level;
    case (ctrl.mode)
      MODE_DIFFERENTIAL: begin
        off_effective = settings.on_level + settings.delta;
      end
      MODE_COMPARATOR: begin
        next_compared = actual_x - actual_y;
      end
      default: begin
      end
    endcase
  end

  // Sign of delta picks hysteresis or window through on versus off
  hysteresis_decide decide (
    .value_in (next_compared),
    .on_in    (settings.on_level),
    .off_in   (off_effective),
    .prev_in  (SWITCH_OUT),
    .next_out (next_switch)
  );

  // Raw integers are compared; no decimal shift is applied here
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      SWITCH_OUT <= 1'b0;
    end else if (deciding) begin
      SWITCH_OUT <= next_switch;
    end
  end

  // Last compared value is kept for software to read back
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      compared <= '0;
    end else if (deciding) begin
      compared <= next_compared;
    end
  end

  // Wraps after 2^32 evaluations; software takes differences
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      eval_count <= 32'h00000000;
    end else if (deciding) begin
      eval_count <= eval_count + 32'h00000001;
    end
  end

  // ==========================================================
  // Read data; unmapped addresses read zero and ignore writes
  always_comb begin
    case (WB_ADR_IN)
      `ADDR_CTRL: begin
        next_dat = 32'h00000000;
        next_dat[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = ctrl.mode;
        next_dat[`CTRL_ENABLE_BIT]              = ctrl.enable;
        next_dat[`CTRL_DEC_MSB:`CTRL_DEC_LSB]   = ctrl.decimals;
      end
      `ADDR_GAIN:       next_dat = settings.gain;
      `ADDR_OFFSET:     next_dat = settings.offset;
      `ADDR_ON:         next_dat = settings.on_level;
      `ADDR_OFF:        next_dat = settings.off_level;
      `ADDR_DELTA:      next_dat = settings.delta;
      `ADDR_STATUS: begin
        next_dat = 32'h00000000;
        next_dat[`STAT_SWITCH_BIT] = SWITCH_OUT;
        next_dat[`STAT_BUSY_BIT]   = BUSY_OUT;
      end
      `ADDR_ACTUAL_X:   next_dat = actual_x;
      `ADDR_ACTUAL_Y:   next_dat = actual_y;
      `ADDR_COMPARED:   next_dat = compared;
      `ADDR_EVAL_COUNT: next_dat = eval_count;
      default:          next_dat = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      WB_DAT_OUT <= 32'h00000000;
    // Loaded only on a taken read, so the word stands through the ack
    end else if (bus_read) begin
      WB_DAT_OUT <= next_dat;
    end
  end

endmodule

//--- rtl/hysteresis_decide.sv
// Chooses the next switch level from value, thresholds and previous level
module hysteresis_decide (
  input  wire logic signed [31:0] value_in,  // Value being compared
  input  wire logic signed [31:0] on_in,     // On threshold
  input  wire logic signed [31:0] off_in,    // Off threshold
  input  wire logic               prev_in,   // Present switch level
  output logic                    next_out   // Next switch level
);

  always_comb begin
    if (on_in >= off_in) begin
      if (value_in > on_in) begin
        next_out = 1'b1;
      end else if (value_in <= off_in) begin
        next_out = 1'b0;
      end else begin
        next_out = prev_in;
      end
    end else begin
      next_out = (value_in >= on_in) && (value_in < off_in);
    end
  end

endmodule

//--- rtl/trigger_cfg.svh
// Register offsets, field positions, reset values and limits of the trigger
`ifndef TRIGGER_CFG_SVH
`define TRIGGER_CFG_SVH

// ==========================================================
// Register byte offsets
`define ADDR_CTRL       8'h00
`define ADDR_GAIN       8'h04
`define ADDR_OFFSET     8'h08
`define ADDR_ON         8'h0C
`define ADDR_OFF        8'h10
`define ADDR_DELTA      8'h14
`define ADDR_STATUS     8'h18
`define ADDR_ACTUAL_X   8'h1C
`define ADDR_ACTUAL_Y   8'h20
`define ADDR_COMPARED   8'h24
`define ADDR_EVAL_COUNT 8'h28

// ==========================================================
// Control field positions
`define CTRL_MODE_LSB   0
`define CTRL_MODE_MSB   1
`define CTRL_ENABLE_BIT 2
`define CTRL_DEC_LSB    4
`define CTRL_DEC_MSB    5

// ==========================================================
// Status field positions
`define STAT_SWITCH_BIT 0
`define STAT_BUSY_BIT   1

// ==========================================================
// Reset values
`define RESET_CTRL      32'h00000000
`define RESET_GAIN      32'h00000064
`define RESET_OFFSET    32'h00000000
`define RESET_ON        32'h00000000
`define RESET_OFF       32'h00000000
`define RESET_DELTA     32'h00000000

// ==========================================================
// Parameter limits; gain counts in hundredths
`define GAIN_SCALE      32'h00000064
`define GAIN_MAX        32'h000003E8
`define GAIN_MIN        32'hFFFFFC18
`define OFFSET_MAX      32'h00002710
`define OFFSET_MIN      32'hFFFFD8F0
`define LEVEL_MAX       32'h00004E20
`define LEVEL_MIN       32'hFFFFB1E0

`endif

//--- rtl/trigger_pkg.sv
// Types shared by the analog hysteresis trigger modules
package trigger_pkg;

  // ==========================================================
  // Modes and evaluation states
  typedef enum logic [1:0] {
    MODE_THRESHOLD    = 2'h0,
    MODE_DIFFERENTIAL = 2'h1,
    MODE_COMPARATOR   = 2'h2,
    MODE_SPARE        = 2'h3
  } mode_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SCALE  = 3'b010,
    ST_DECIDE = 3'b100
  } eval_state_t;

  // ==========================================================
  // Grouped settings
  typedef struct packed {
    mode_t      mode;
    logic       enable;
    logic [1:0] decimals;
  } ctrl_t;

  typedef struct packed {
    logic signed [31:0] gain;
    logic signed [31:0] offset;
    logic signed [31:0] on_level;
    logic signed [31:0] off_level;
    logic signed [31:0] delta;
  } settings_t;

  typedef struct packed {
    logic signed [15:0] first;
    logic signed [15:0] second;
  } sample_t;

endpackage

//--- rtl/value_scaler.sv
// Scales one analog value by gain in hundredths and adds the offset
module value_scaler #(
  parameter int IN_WIDTH = 16
) (
  input  wire logic signed [IN_WIDTH-1:0] value_in,  // Raw analog value
  input  wire logic signed [31:0]         gain_in,   // Gain, hundredths
  input  wire logic signed [31:0]         offset_in, // Zero offset
  output logic signed [31:0]              scaled_out // Scaled value
);
  `include "trigger_cfg.svh"

  logic signed [47:0] product;
  logic signed [47:0] quotient;

  // Division truncates toward zero, so the result is symmetric about zero
  always_comb begin
    product    = 48'(value_in) * 48'(gain_in);
    quotient   = product / 48'(signed'(`GAIN_SCALE));
    scaled_out = 32'(quotient) + offset_in;
  end

endmodule

//--- sim/analog_hysteresis_trigger_test.sv
// Self-checking bench for the analog hysteresis trigger
`include "trigger_cfg.svh"
`define CHECK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  bad_count++; $display("MISMATCH %s expected %h seen %h", nm, e, g); \
  end end
module analog_hysteresis_trigger_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] dat_out;
  logic        ack;
  logic [15:0] first;
  logic [15:0] second;
  logic        cycle_en;
  logic        sw;
  logic        busy;
  logic [31:0] cnt;
  int          bad_count = 0;
  int          n_compared = 0;

  always #12.5 clock = ~clock;

  analog_source u_analog_source (.clock_in(clock), .first_out(first),
    .second_out(second), .cycle_en_out(cycle_en));
  analog_hysteresis_trigger u_analog_hysteresis_trigger (
    .CLOCK_IN(clock), .RESETN_IN(resetn), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
    .WB_DAT_IN(dat), .WB_DAT_OUT(dat_out), .WB_ACK_OUT(ack),
    .FIRST_ANALOG_IN(first), .SECOND_ANALOG_IN(second),
    .CYCLE_EN_IN(cycle_en), .SWITCH_OUT(sw), .BUSY_OUT(busy));

  // ==========================================================
  // Bus and evaluation helpers
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    @(posedge clock);
    while (ack !== 1'b1) @(posedge clock);
    q = dat_out;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic chk_reg(input string nm, input logic [7:0] a,
                         input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h00000000, q);
    `CHECK(nm, e, q)
  endtask
  task automatic setup(input logic [31:0] c, g, o, on, off, dl);
    wr(`ADDR_CTRL, c);
    wr(`ADDR_GAIN, g);
    wr(`ADDR_OFFSET, o);
    wr(`ADDR_ON, on);
    wr(`ADDR_OFF, off);
    wr(`ADDR_DELTA, dl);
  endtask
  // Pulse waits out the fixed two-cycle evaluation before looking
  task automatic ev(input logic [15:0] x, y, input logic e,
                    input logic b = 1'b1);
    u_analog_source.fire(x, y);
    @(posedge clock);
    `CHECK("busy", b, busy)
    repeat (2) @(posedge clock);
    `CHECK("switch", e, sw)
  endtask
  task automatic seq(input logic [15:0] xs[$], input logic es[$]);
    foreach (xs[i]) ev(xs[i], 16'h0000, es[i]);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset_values;
    `CHECK("switch_rst", 1'b0, sw)
    chk_reg("ctrl", `ADDR_CTRL, `RESET_CTRL);
    chk_reg("gain", `ADDR_GAIN, `RESET_GAIN);
    chk_reg("count", `ADDR_EVAL_COUNT, 32'h00000000);
    chk_reg("unmapped", 8'h3C, 32'h00000000);
  endtask
  task automatic t_limits;
    logic [7:0]  la[7] = '{`ADDR_GAIN, `ADDR_GAIN, `ADDR_OFFSET,
      `ADDR_OFFSET, `ADDR_ON, `ADDR_OFF, `ADDR_DELTA};
    logic [31:0] lw[7] = '{32'h000007D0, 32'hFFFFF830, 32'h00004E20,
      32'hFFFFB1E0, 32'h00007530, 32'hFFFF8AD0, 32'h00007530};
    logic [31:0] le[7] = '{`GAIN_MAX, `GAIN_MIN, `OFFSET_MAX,
      `OFFSET_MIN, `LEVEL_MAX, `LEVEL_MIN, `LEVEL_MAX};
    foreach (la[i]) begin
      wr(la[i], lw[i]);
      chk_reg("limit", la[i], le[i]);
    end
  endtask
  task automatic t_hysteresis;
    setup(32'h00000004, 32'h00000064, 32'h0, 32'h00000064,
          32'h00000032, 32'h0);
    seq('{120, 80, 50, 80, 101, 100}, '{1, 1, 0, 0, 1, 1});
  endtask
  task automatic t_window;
    setup(32'h00000004, 32'h00000064, 32'h0, 32'h0000000A,
          32'h00000014, 32'h0);
    seq('{15, 9, 10, 19, 20}, '{1, 0, 1, 1, 0});
  endtask
  task automatic t_scaling;
    setup(32'h00000034, 32'hFFFFFF06, 32'h0000012C, 32'h000000C7,
          32'h00000064, 32'h0);
    ev(16'd40, 16'h0000, 1'b1);
    chk_reg("actual_x", `ADDR_ACTUAL_X, 32'h000000C8);
    chk_reg("compared", `ADDR_COMPARED, 32'h000000C8);
    ev(16'd7, 16'h0000, 1'b1);
    chk_reg("actual_x", `ADDR_ACTUAL_X, 32'h0000011B);
  endtask
  task automatic t_differential;
    setup(32'h00000005, 32'h00000064, 32'h0, 32'h00000064,
          32'h00001000, 32'hFFFFFFE2);
    seq('{101, 71, 70, 100}, '{1, 1, 0, 0});
    wr(`ADDR_DELTA, 32'h0000001E);
    seq('{100, 129, 130, 99}, '{1, 1, 0, 0});
  endtask
  task automatic t_comparator;
    setup(32'h00000006, 32'h000000C8, 32'h00000005, 32'h0000000A,
          32'h0, 32'h0);
    ev(16'd10, 16'd4, 1'b1);
    chk_reg("compared", `ADDR_COMPARED, 32'h0000000C);
    chk_reg("actual_y", `ADDR_ACTUAL_Y, 32'h0000000D);
    chk_reg("status", `ADDR_STATUS, 32'h00000001);
    ev(16'd7, 16'd4, 1'b1);
    ev(16'd4, 16'd4, 1'b0);
    ev(16'd4, 16'd10, 1'b0);
  endtask
  task automatic t_disabled;
    wb(1'b0, `ADDR_EVAL_COUNT, 32'h0, cnt);
    setup(32'h00000000, 32'h00000064, 32'h0, 32'h0000000A,
          32'h00000005, 32'h0);
    ev(16'd50, 16'h0000, 1'b0, 1'b0);
    chk_reg("count", `ADDR_EVAL_COUNT, cnt);
    wr(`ADDR_CTRL, 32'h00000007);
    ev(16'd50, 16'h0000, 1'b1);
    chk_reg("count", `ADDR_EVAL_COUNT, cnt + 32'h1);
  endtask

  // ==========================================================
  // Sequence, watchdog and verdict
  task automatic give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    t_reset_values();
    t_limits();
    t_hysteresis();
    t_window();
    t_scaling();
    t_differential();
    t_comparator();
    t_disabled();
    give_verdict();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    give_verdict();
  end
endmodule

//--- sim/analog_source.sv
// Model of the analog channels and program cycle feeding the trigger
module analog_source (
  input  wire logic   clock_in,     // Clock
  output logic [15:0] first_out,    // First analog value
  output logic [15:0] second_out,   // Second analog value
  output logic        cycle_en_out  // Program cycle pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    first_out = 16'h0000;
    second_out = 16'h0000;
    cycle_en_out = 1'b0;
  end
  // Analog levels hold between cycles, as a channel would
  task automatic fire(input logic [15:0] x, input logic [15:0] y);
    @(posedge clock_in);
    first_out <= x;
    second_out <= y;
    cycle_en_out <= 1'b1;
    @(posedge clock_in);
    cycle_en_out <= 1'b0;
  endtask
endmodule

//--- sim/trigger_monitor.sv
// Concurrent checks on the trigger's bus and evaluation ports
module trigger_monitor (
  input wire logic        CLOCK_IN,    // Clock
  input wire logic        RESETN_IN,   // Reset, active low
  input wire logic        WB_CYC_IN,   // Bus cycle
  input wire logic        WB_STB_IN,   // Bus strobe
  input wire logic [31:0] WB_DAT_OUT,  // Read data
  input wire logic        WB_ACK_OUT,  // Acknowledge
  input wire logic        CYCLE_EN_IN, // Program cycle pulse
  input wire logic        SWITCH_OUT,  // Switch output
  input wire logic        BUSY_OUT     // Evaluation running
);
  // Flops hold unknown values until the first edge applies the reset
  logic edge_seen;
  initial edge_seen = 1'b0;
  always @(posedge CLOCK_IN) edge_seen <= 1'b1;

  // ==========================================================
  // Bus handshake
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);

  a_ack_follows_req: assert property (
    WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
    else $error("ack did not follow a request");
  a_ack_one_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack stood longer than one cycle");
  a_ack_has_cause: assert property (
    WB_ACK_OUT |-> $past(WB_CYC_IN && WB_STB_IN))
    else $error("ack without a request");
  a_data_on_ack: assert property ($changed(WB_DAT_OUT) |-> WB_ACK_OUT)
    else $error("read data moved outside an ack");

  // ==========================================================
  // Evaluation timing
  a_busy_two_cycles: assert property (
    $rose(BUSY_OUT) |-> BUSY_OUT[*2] ##1 !BUSY_OUT)
    else $error("evaluation did not last two cycles");
  a_busy_has_cause: assert property (
    $rose(BUSY_OUT) |-> $past(CYCLE_EN_IN))
    else $error("evaluation started without a cycle pulse");
  a_switch_at_end: assert property (
    $changed(SWITCH_OUT) |-> $fell(BUSY_OUT))
    else $error("switch moved outside the end of an evaluation");
  a_reset_quiet: assert property (
    disable iff (1'b0)
    edge_seen && !RESETN_IN |-> !SWITCH_OUT && !WB_ACK_OUT && !BUSY_OUT)
    else $error("outputs not low during reset");

  c_bus_ack: cover property (WB_ACK_OUT);
  c_eval: cover property ($fell(BUSY_OUT));
  c_switch_on: cover property ($rose(SWITCH_OUT));
endmodule

bind analog_hysteresis_trigger trigger_monitor u_trigger_monitor (
  .CLOCK_IN(CLOCK_IN), .RESETN_IN(RESETN_IN), .WB_CYC_IN(WB_CYC_IN),
  .WB_STB_IN(WB_STB_IN), .WB_DAT_OUT(WB_DAT_OUT),
  .WB_ACK_OUT(WB_ACK_OUT), .CYCLE_EN_IN(CYCLE_EN_IN),
  .SWITCH_OUT(SWITCH_OUT), .BUSY_OUT(BUSY_OUT));
